//--- dram_bank_params.svh
// Constants for the bank-state and write-buffer block
`ifndef DRAM_BANK_PARAMS_SVH
`define DRAM_BANK_PARAMS_SVH
`define BANK_COUNT   32
`define BANK_BITS    5
`define COL_BITS     7
`define LANE_BYTES   8
`define LANE_BITS    64
`define WORD_BYTES   16
`define WORD_BITS    128
`define SYNC_W       179
`define RESET_ACTIVE 32'h0000_0000
`define FULL_MASK    16'hffff
`endif

//--- dram_bank_pkg.sv
// Types for the bank-state and write-buffer block
package dram_bank_pkg;
  typedef enum logic [2:0] {
    ROW_NOP               = 3'h0,
    ROW_ACTIVATE          = 3'h1,
    ROW_PRECHARGE         = 3'h2,
    ROW_REFRESH_ACTIVATE  = 3'h3,
    ROW_REFRESH_PRECHARGE = 3'h4
  } row_op_t;
  typedef enum logic [2:0] {
    COL_NOP                  = 3'h0,
    COL_WRITE                = 3'h1,
    COL_READ                 = 3'h2,
    COL_COLUMN_PRECHARGE     = 3'h3,
    COL_WRITE_WITH_PRECHARGE = 3'h4,
    COL_READ_WITH_PRECHARGE  = 3'h5
  } col_op_t;
endpackage : dram_bank_pkg

//--- link_sync.sv
// Three-stage synchroniser for link inputs
`timescale 1ns/10ps
`default_nettype none
`include "dram_bank_params.svh"
module link_sync (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // Asynchronous input
  input  wire logic [`SYNC_W-1:0]   i_d,
  // Second and third stages
  output logic      [`SYNC_W-1:0]   o_s2,
  output logic      [`SYNC_W-1:0]   o_s3
);
  logic [`SYNC_W-1:0] s1;
  logic [`SYNC_W-1:0] s2;
  logic [`SYNC_W-1:0] s3;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign o_s2 = s2;
  assign o_s3 = s3;
endmodule : link_sync
`default_nettype wire

//--- dram_bank_ctrl.sv
// Device bank state, write buffer and byte-mask retire logic
`timescale 1ns/10ps
`default_nettype none
`include "dram_bank_params.svh"
// Function
// [R01] Controller sends mask packet one fixed interval after a partial write.
// [R02] Mask packet shares the slot of the column command that retires the write.
// [R03] Unused mask slot of a full write may carry an extended packet.
// [R04] Mask-select clear in the mask slot stores all sixteen bytes.
// [R05] Reads never get a mask packet; their slot carries extended packets.
// [R06] Each mask bit gates one byte across both lanes; one stores, zero keeps.
// [R07] Activates to different devices need only the packet interval.
// [R08] Same-device activates to non-adjacent banks wait the row-to-row time.
// [R09] Same or adjacent bank re-activate needs a precharge and row cycle.
// [R10] Precharge after activate elsewhere needs only the packet interval.
// [R11] Precharge to same or adjacent bank waits active-to-precharge time.
// [R12] Activate far from a precharged bank needs only the packet interval.
// [R13] Activate two banks away waits packet or precharge time per middle bank.
// [R14] Activate to same or adjacent bank waits the precharge time.
// [R15] Same-device precharges are spaced by precharge-to-precharge time.
// [R16] Two adjacent banks are never active together.
// [R17] Precharge to an active bank also clears both its sense amps.
// [R18] Precharge next to an active bank precharges that neighbour.
// [R19] Refresh activate and precharge act exactly as activate and precharge.
// [R20] Read or retire to a fresh bank waits the row-to-column delay.
// [R21] No read or retire to a bank adjacent to an activated bank.
// [R22] Column-scheduled precharges obey the row precharge spacing.
// [R23] Mask packet holds two eight-bit lane masks for write commands.
// [R24] Column packets are sent only in the attention power state.
// [R25] Controller tracks bank state and times to enforce spacing.
module dram_bank_ctrl (
  // Clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  // Channel clock
  input  wire logic                    i_chan_clk,
  // Row packet
  input  wire logic                    i_row_valid,
  input  wire dram_bank_pkg::row_op_t  i_row_op,
  input  wire logic [`BANK_BITS-1:0]   i_row_bank,
  // Column command packet
  input  wire logic                    i_col_valid,
  input  wire dram_bank_pkg::col_op_t  i_col_op,
  input  wire logic [`BANK_BITS-1:0]   i_col_bank,
  input  wire logic [`COL_BITS-1:0]    i_col_addr,
  // Mask or extended packet
  input  wire logic                    i_ext_valid,
  input  wire logic                    i_ext_mask_sel,
  input  wire logic [`LANE_BYTES-1:0]  i_lane_a_byte_mask,
  input  wire logic [`LANE_BYTES-1:0]  i_lane_b_byte_mask,
  input  wire logic                    i_ext_precharge,
  input  wire logic [`BANK_BITS-1:0]   i_ext_bank,
  // Write data packet
  input  wire logic                    i_data_valid,
  input  wire logic [`LANE_BITS-1:0]   i_data_lane_a,
  input  wire logic [`LANE_BITS-1:0]   i_data_lane_b,
  // Bank state
  output logic      [`BANK_COUNT-1:0]  o_bank_active,
  output logic                         o_illegal_activate,
  // Retired write
  output logic                         o_retire_valid,
  output logic      [`BANK_BITS-1:0]   o_retire_bank,
  output logic      [`COL_BITS-1:0]    o_retire_col,
  output logic      [`WORD_BITS-1:0]   o_retire_data,
  output logic      [`WORD_BYTES-1:0]  o_retire_byte_en
);
  import dram_bank_pkg::*;

  function automatic logic [`BANK_COUNT-1:0] precharge_banks(
    input logic [`BANK_COUNT-1:0] act,
    input logic [`BANK_BITS-1:0]  b
  );
    logic [`BANK_COUNT-1:0] r;
    r = act;
    for (int i = 0; i < `BANK_COUNT; i++) begin
      if (i == int'(b) || i == int'(b) + 1 || i + 1 == int'(b)) begin
        r[i] = 1'b0; // [R17] [R18]
      end
    end
    return r;
  endfunction : precharge_banks

  function automatic logic near_active(
    input logic [`BANK_COUNT-1:0] act,
    input logic [`BANK_BITS-1:0]  b
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `BANK_COUNT; i++) begin
      if ((i == int'(b) + 1 || i + 1 == int'(b)) && act[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : near_active

  // Synchronised link inputs
  logic [`SYNC_W-1:0] s2;
  logic [`SYNC_W-1:0] s3;

  link_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_chan_clk, i_row_valid, i_row_op, i_row_bank,
               i_col_valid, i_col_op, i_col_bank, i_col_addr,
               i_ext_valid, i_ext_mask_sel, i_lane_a_byte_mask,
               i_lane_b_byte_mask, i_ext_precharge, i_ext_bank,
               i_data_valid, i_data_lane_a, i_data_lane_b}),
    .o_s2    (s2),
    .o_s3    (s3)
  );

  logic                   ck2;
  logic                   ck3;
  logic                   row_v;
  logic [2:0]             row_op_raw;
  row_op_t                row_op;
  logic [`BANK_BITS-1:0]  row_bank;
  logic                   col_v;
  logic [2:0]             col_op_raw;
  col_op_t                col_op;
  logic [`BANK_BITS-1:0]  col_bank;
  logic [`COL_BITS-1:0]   col_addr;
  logic                   ext_v;
  logic                   ext_msel;
  logic [`LANE_BYTES-1:0] mask_a;
  logic [`LANE_BYTES-1:0] mask_b;
  logic                   ext_pre;
  logic [`BANK_BITS-1:0]  ext_bank;
  logic                   dat_v;
  logic [`LANE_BITS-1:0]  dat_a;
  logic [`LANE_BITS-1:0]  dat_b;

  assign ck2 = s2[`SYNC_W-1];
  assign {ck3, row_v, row_op_raw, row_bank, col_v, col_op_raw, col_bank,
          col_addr, ext_v, ext_msel, mask_a, mask_b, ext_pre, ext_bank,
          dat_v, dat_a, dat_b} = s3;
  assign row_op = row_op_t'(row_op_raw);
  assign col_op = col_op_t'(col_op_raw);

  // State
  logic                    clk_hi;
  logic [`BANK_COUNT-1:0]  active;
  logic                    wb_full;
  logic [`BANK_BITS-1:0]   wb_bank;
  logic [`COL_BITS-1:0]    wb_col;
  logic [`WORD_BITS-1:0]   wb_data;
  logic                    illegal;
  logic                    ret_v;
  logic [`BANK_BITS-1:0]   ret_bank;
  logic [`COL_BITS-1:0]    ret_col;
  logic [`WORD_BITS-1:0]   ret_data;
  logic [`WORD_BYTES-1:0]  ret_en;

  logic                    next_clk_hi;
  logic [`BANK_COUNT-1:0]  next_active;
  logic                    next_wb_full;
  logic [`BANK_BITS-1:0]   next_wb_bank;
  logic [`COL_BITS-1:0]    next_wb_col;
  logic [`WORD_BITS-1:0]   next_wb_data;
  logic                    next_illegal;
  logic                    next_ret_v;
  logic [`BANK_BITS-1:0]   next_ret_bank;
  logic [`COL_BITS-1:0]    next_ret_col;
  logic [`WORD_BITS-1:0]   next_ret_data;
  logic [`WORD_BYTES-1:0]  next_ret_en;

  logic edge_seen;
  logic retiring;
  logic row_act;
  logic row_pre;
  logic col_pre;

  always_comb begin
    edge_seen = (ck2 == ck3) && ck3 && !clk_hi;
    next_clk_hi = (ck2 == ck3) ? ck3 : clk_hi;
    // Refresh commands share the plain command paths
    row_act = row_v && (row_op == ROW_ACTIVATE ||
                        row_op == ROW_REFRESH_ACTIVATE); // [R19]
    row_pre = row_v && (row_op == ROW_PRECHARGE ||
                        row_op == ROW_REFRESH_PRECHARGE); // [R19]
    col_pre = col_v && (col_op == COL_COLUMN_PRECHARGE ||
                        col_op == COL_WRITE_WITH_PRECHARGE ||
                        col_op == COL_READ_WITH_PRECHARGE);
    retiring = col_v && col_op != COL_READ &&
               col_op != COL_READ_WITH_PRECHARGE;
    next_active   = active;
    next_wb_full  = wb_full;
    next_wb_bank  = wb_bank;
    next_wb_col   = wb_col;
    next_wb_data  = wb_data;
    next_illegal  = 1'b0;
    next_ret_v    = 1'b0;
    next_ret_bank = ret_bank;
    next_ret_col  = ret_col;
    next_ret_data = ret_data;
    next_ret_en   = ret_en;
    if (edge_seen) begin
      if (row_pre) begin
        next_active = precharge_banks(next_active, row_bank); // [R17] [R18]
      end
      if (row_act) begin
        if (near_active(next_active, row_bank) ||
            next_active[row_bank]) begin
          next_illegal = 1'b1; // [R16]
        end else begin
          next_active[row_bank] = 1'b1; // [R16]
        end
      end
      if (dat_v) begin
        next_wb_data = {dat_b, dat_a};
      end
      if (retiring && wb_full) begin
        next_ret_v    = 1'b1; // [R02]
        next_ret_bank = wb_bank;
        next_ret_col  = wb_col;
        next_ret_data = wb_data;
        if (ext_v && ext_msel) begin
          next_ret_en = {mask_b, mask_a}; // [R06] [R23]
        end else begin
          next_ret_en = `FULL_MASK; // [R04]
        end
        next_wb_full = 1'b0;
      end
      if (col_v && (col_op == COL_WRITE ||
                    col_op == COL_WRITE_WITH_PRECHARGE)) begin
        next_wb_full = 1'b1;
        next_wb_bank = col_bank;
        next_wb_col  = col_addr;
      end
      if (col_pre) begin
        next_active = precharge_banks(next_active, col_bank); // [R17]
      end
      if (ext_v && !ext_msel && ext_pre) begin
        next_active = precharge_banks(next_active, ext_bank); // [R18]
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      clk_hi   <= 1'b0;
      active   <= `RESET_ACTIVE;
      wb_full  <= 1'b0;
      wb_bank  <= '0;
      wb_col   <= '0;
      wb_data  <= '0;
      illegal  <= 1'b0;
      ret_v    <= 1'b0;
      ret_bank <= '0;
      ret_col  <= '0;
      ret_data <= '0;
      ret_en   <= '0;
    end else begin
      clk_hi   <= next_clk_hi;
      active   <= next_active;
      wb_full  <= next_wb_full;
      wb_bank  <= next_wb_bank;
      wb_col   <= next_wb_col;
      wb_data  <= next_wb_data;
      illegal  <= next_illegal;
      ret_v    <= next_ret_v;
      ret_bank <= next_ret_bank;
      ret_col  <= next_ret_col;
      ret_data <= next_ret_data;
      ret_en   <= next_ret_en;
    end
  end

  assign o_bank_active      = active;
  assign o_illegal_activate = illegal;
  assign o_retire_valid     = ret_v;
  assign o_retire_bank      = ret_bank;
  assign o_retire_col       = ret_col;
  assign o_retire_data      = ret_data;
  assign o_retire_byte_en   = ret_en;
endmodule : dram_bank_ctrl
`default_nettype wire

//--- dram_bank_checker.sv
// Port checks for the bank-state and write-buffer block
`timescale 1ns/10ps
`default_nettype none
`include "dram_bank_params.svh"
module dram_bank_checker (
  // Clock and reset
  input wire logic                      i_mclk,
  input wire logic                      i_rst_n,
  // Packets
  input wire logic                      i_row_valid,
  input wire dram_bank_pkg::row_op_t    i_row_op,
  input wire logic                      i_col_valid,
  input wire dram_bank_pkg::col_op_t    i_col_op,
  input wire logic                      i_ext_valid,
  input wire logic                      i_ext_mask_sel,
  input wire logic [`LANE_BYTES-1:0]    i_lane_a_byte_mask,
  input wire logic [`LANE_BYTES-1:0]    i_lane_b_byte_mask,
  input wire logic                      i_ext_precharge,
  // Outputs
  input wire logic [`BANK_COUNT-1:0]    o_bank_active,
  input wire logic                      o_illegal_activate,
  input wire logic                      o_retire_valid,
  input wire logic [`WORD_BYTES-1:0]    o_retire_byte_en
);
  import dram_bank_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic act_op;
  logic pre_op;
  logic msk;
  assign act_op = i_row_valid && (i_row_op == ROW_ACTIVATE ||
                  i_row_op == ROW_REFRESH_ACTIVATE);
  assign pre_op = (i_row_valid && (i_row_op == ROW_PRECHARGE ||
                  i_row_op == ROW_REFRESH_PRECHARGE)) || (i_col_valid &&
                  i_col_op inside {COL_COLUMN_PRECHARGE,
                  COL_WRITE_WITH_PRECHARGE, COL_READ_WITH_PRECHARGE}) ||
                  (i_ext_valid && !i_ext_mask_sel && i_ext_precharge);
  assign msk = i_ext_valid && i_ext_mask_sel;
  AST_RETIRE_PULSE: assert property (o_retire_valid |=> !o_retire_valid)
    else $error("retire strobe longer than one cycle");
  AST_NO_ADJACENT: assert property (!(|(o_bank_active & (o_bank_active >> 1))))
    else $error("two adjacent banks active");
  AST_SET_BY_ACT: assert property (|(o_bank_active & ~$past(o_bank_active))
    |-> act_op) else $error("bank opened without activate");
  AST_CLEAR_BY_PRE: assert property (|(~o_bank_active & $past(o_bank_active))
    |-> pre_op) else $error("bank closed without precharge");
  AST_ILLEGAL_CAUSE: assert property (o_illegal_activate
    |-> act_op && $past(o_bank_active) != '0) else $error("bad refusal");
  AST_RETIRE_CAUSE: assert property (o_retire_valid |-> i_col_valid &&
    !(i_col_op inside {COL_READ, COL_READ_WITH_PRECHARGE}))
    else $error("retire without retiring packet");
  AST_FULL_MASK: assert property (o_retire_valid && !msk
    |-> o_retire_byte_en == `FULL_MASK) else $error("full write masked");
  AST_MASK_MAP: assert property (o_retire_valid && msk |-> o_retire_byte_en
    == {i_lane_b_byte_mask, i_lane_a_byte_mask}) else $error("mask mapping");
  cover property (o_retire_valid && msk);
  cover property (o_illegal_activate);
  cover property (o_bank_active != '0);
endmodule : dram_bank_checker
bind dram_bank_ctrl dram_bank_checker u_chk (.i_mclk, .i_rst_n,
  .i_row_valid, .i_row_op, .i_col_valid, .i_col_op, .i_ext_valid,
  .i_ext_mask_sel, .i_lane_a_byte_mask, .i_lane_b_byte_mask,
  .i_ext_precharge, .o_bank_active, .o_illegal_activate, .o_retire_valid,
  .o_retire_byte_en);
`default_nettype wire

//--- chan_host.sv
// Channel clock source of the controller model
`timescale 1ns/10ps
`default_nettype none
module chan_host (
  // Clock
  input  wire logic i_mclk,
  // Channel clock
  output var  logic o_chan_clk
);
  // Clock idles low outside frames
  initial o_chan_clk = 1'b0;
  // One frame per period
  // Same spacing for all
  task automatic edge_out;
    repeat (8) @(posedge i_mclk);
    o_chan_clk <= 1'b1;
    repeat (16) @(posedge i_mclk);
    o_chan_clk <= 1'b0;
    repeat (8) @(posedge i_mclk);
  endtask : edge_out
endmodule : chan_host
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the bank-state and write-buffer block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dram_bank_pkg::*;
  logic         i_mclk = 1'b0, i_rst_n = 1'b0, i_chan_clk;
  logic         i_row_valid = 1'b0, i_col_valid = 1'b0, i_ext_valid = 1'b0;
  logic         i_ext_mask_sel = 1'b0, i_ext_precharge = 1'b0;
  logic         i_data_valid = 1'b0;
  row_op_t      i_row_op = ROW_NOP;
  col_op_t      i_col_op = COL_NOP;
  logic [4:0]   i_row_bank = 5'h00, i_col_bank = 5'h00, i_ext_bank = 5'h00;
  logic [6:0]   i_col_addr = 7'h00;
  logic [7:0]   i_lane_a_byte_mask = 8'h00, i_lane_b_byte_mask = 8'h00;
  logic [63:0]  i_data_lane_a = 64'h0, i_data_lane_b = 64'h0;
  logic [31:0]  o_bank_active;
  logic         o_illegal_activate, o_retire_valid;
  logic [4:0]   o_retire_bank;
  logic [6:0]   o_retire_col;
  logic [127:0] o_retire_data;
  logic [15:0]  o_retire_byte_en;
  int           failures = 0, comparisons = 0, ill_cnt = 0, ret_cnt = 0;
  always #2.5 i_mclk = ~i_mclk;
  chan_host u_host (.i_mclk, .o_chan_clk(i_chan_clk));
  dram_bank_ctrl u_dut (.i_mclk, .i_rst_n, .i_chan_clk, .i_row_valid,
    .i_row_op, .i_row_bank, .i_col_valid, .i_col_op, .i_col_bank, .i_col_addr,
    .i_ext_valid, .i_ext_mask_sel, .i_lane_a_byte_mask, .i_lane_b_byte_mask,
    .i_ext_precharge, .i_ext_bank, .i_data_valid, .i_data_lane_a,
    .i_data_lane_b, .o_bank_active, .o_illegal_activate, .o_retire_valid,
    .o_retire_bank, .o_retire_col, .o_retire_data, .o_retire_byte_en);
  always @(posedge i_mclk) begin
    ill_cnt <= ill_cnt + int'(o_illegal_activate === 1'b1);
    ret_cnt <= ret_cnt + int'(o_retire_valid === 1'b1);
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // One channel clock frame, then release lines
  task automatic frame;
    u_host.edge_out();
    i_row_valid <= 1'b0;
    i_col_valid <= 1'b0;
    i_ext_valid <= 1'b0;
    i_data_valid <= 1'b0;
    i_data_lane_a <= ~i_data_lane_a;
    i_data_lane_b <= ~i_data_lane_b;
  endtask : frame
  task automatic row(input row_op_t op, input logic [4:0] b);
    @(posedge i_mclk);
    i_row_valid <= 1'b1;
    i_row_op    <= op;
    i_row_bank  <= b;
    frame();
  endtask : row
  task automatic col(input col_op_t op, input logic [4:0] b,
      input logic [6:0] a, input logic e, m, p, input logic [4:0] x,
      input logic [15:0] mk);
    @(posedge i_mclk);
    i_col_valid <= 1'b1;
    i_col_op    <= op;
    {i_col_bank, i_col_addr} <= {b, a};
    {i_ext_valid, i_ext_mask_sel, i_ext_precharge, i_ext_bank} <= {e, m, p, x};
    {i_lane_b_byte_mask, i_lane_a_byte_mask} <= mk;
    frame();
  endtask : col
  task automatic dat(input logic [63:0] a, input logic [63:0] b);
    @(posedge i_mclk);
    {i_data_valid, i_data_lane_a, i_data_lane_b} <= {1'b1, a, b};
    frame();
  endtask : dat
  task automatic t_act;
    row(ROW_ACTIVATE, 5'h04);
    row(ROW_REFRESH_ACTIVATE, 5'h0a);
    check(o_bank_active, 32'h0000_0410);
    row(ROW_ACTIVATE, 5'h05);
    check(ill_cnt, 1);
    check(o_bank_active, 32'h0000_0410);
  endtask : t_act
  task automatic t_pre;
    row(ROW_PRECHARGE, 5'h05);
    check(o_bank_active, 32'h0000_0400);
    row(ROW_REFRESH_PRECHARGE, 5'h0a);
    check(o_bank_active, 32'h0);
    row(ROW_ACTIVATE, 5'h14);
    col(COL_NOP, 5'h00, 7'h00, 1'b1, 1'b0, 1'b1, 5'h15, 16'h0000);
    check(o_bank_active, 32'h0);
    row(ROW_ACTIVATE, 5'h14);
    col(COL_COLUMN_PRECHARGE, 5'h14, 7'h00, 1'b0, 1'b0, 1'b0,
        5'h00, 16'h0000);
    check(o_bank_active, 32'h0);
  endtask : t_pre
  task automatic t_wr;
    col(COL_WRITE, 5'h03, 7'h05, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000);
    dat(64'h0706050403020100, 64'h0f0e0d0c0b0a0908);
    col(COL_NOP, 5'h03, 7'h00, 1'b1, 1'b0, 1'b0, 5'h00, 16'h0000);
    check(o_retire_byte_en, 16'hffff);
    check({o_retire_bank, o_retire_col}, {5'h03, 7'h05});
    check(o_retire_data, {64'h0f0e0d0c0b0a0908, 64'h0706050403020100});
    row(ROW_ACTIVATE, 5'h07);
    col(COL_WRITE_WITH_PRECHARGE, 5'h07, 7'h09, 1'b0, 1'b0, 1'b0,
        5'h00, 16'h0000);
    check(o_bank_active, 32'h0);
    dat(64'h1, 64'h2);
    row(ROW_ACTIVATE, 5'h09);
    col(COL_READ, 5'h09, 7'h01, 1'b1, 1'b0, 1'b0, 5'h00, 16'h0000);
    col(COL_READ_WITH_PRECHARGE, 5'h09, 7'h01, 1'b1, 1'b0, 1'b0,
        5'h00, 16'h0000);
    check(ret_cnt, 1);
    check(o_bank_active, 32'h0);
    col(COL_NOP, 5'h07, 7'h00, 1'b1, 1'b1, 1'b0, 5'h00, 16'hc30f);
    check(ret_cnt, 2);
    check(o_retire_byte_en, 16'hc30f);
    check({o_retire_bank, o_retire_col}, {5'h07, 7'h09});
    check(o_retire_data, {64'h2, 64'h1});
  endtask : t_wr
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_act();
    t_pre();
    t_wr();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
